/* File: logic/rcms_consts.svh */
// Timing constants of the reset, clock and mode-select block
// Counts are in system clock (divided) periods unless noted
`ifndef RCMS_CONSTS_SVH
`define RCMS_CONSTS_SVH

`define RCMS_DIV_RATIO 2
`define RCMS_SYNC_STAGES 2
`define RCMS_RST_HOLD_SYSCLK 2
`define RCMS_MODE_GAP_SYSCLK 4
`define RCMS_FETCH_HALF_SYSCLK 13
`define RCMS_WAIT_POLL_SYSCLK 5
`define RCMS_RST_MIN_SYSCLK 4
`define RCMS_CNT_W 5
`define RCMS_PIN_RST_VAL 1'h0
`define RCMS_RES_RST_VAL 1'h0

`endif

/* File: logic/rcms_pkg.sv */
// Types of the reset, clock and mode-select block
// Assumes nothing beyond the constants header
package rcms_pkg;

	typedef enum logic [1:0] {
		RCMS_ST_RESET = 2'b00,
		RCMS_ST_BOOT = 2'b01,
		RCMS_ST_RUN = 2'b10,
		RCMS_ST_WAIT = 2'b11
	} rcms_state_t;

endpackage

/* File: logic/rcms_sync.sv */
// Two-flop synchroniser for pin levels
// Assumes the inputs are slow levels, not single-cycle pulses
`timescale 1ns/1ps
module rcms_sync #(
	parameter int W = 2,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta_q;

	// First stage feeds only the second stage
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			meta_q <= RST_VAL;
			q <= RST_VAL;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end

endmodule

/* File: logic/rcms_clkdiv.sv */
// Divide-by-two of the oscillator clock
// Assumes only the power-on reset stops it, never the reset pin
`timescale 1ns/1ps
module rcms_clkdiv (
	input wire logic clk,
	input wire logic resetn,
	output logic clk_half_q,
	output logic rise_next
);

	// Toggling flop gives an exact 50% duty cycle
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			clk_half_q <= 1'h0;
		end else begin
			clk_half_q <= ~clk_half_q;
		end
	end

	assign rise_next = ~clk_half_q;

endmodule

/* File: logic/rcms_top.sv */
// Reset output, system clock and mode selection of the processor core
// Assumes clk is the oscillator; reset_input_n and the mode pin are async
`timescale 1ns/1ps
`include "rcms_consts.svh"

// Contract
// R1 - Reset output active high, clock-synchronous
// R2 - Reset pulse whole periods, tracks input
// R3 - Reset output drops two periods after release
// R4 - Reset tied to mode pin gives enhanced
// R5 - Reset output still driven during bus hold
// R6 - System clock is oscillator divided by two
// R7 - System clock 50% duty, timing reference
// R8 - System clock runs during reset and hold
// R9 - Reset input aborts activity, clears, sleeps
// R10 - Reset input synchronised before use
// R11 - First fetch about 6.5 periods after release
// R12 - Source holds reset over four stable periods
// R13 - Mode pin sampled during and after reset
// R14 - Enhanced: high at release, low four later
// R15 - Any other sample pair gives compatible
// R16 - Reset makes mode pin an input
// R17 - Wait suspends if wait pin high
// R18 - Resample every five periods, resume when low
// R19 - Interrupts serviced while waiting if enabled
// R20 - Enhanced: pin is coprocessor busy input
module rcms_top
	import rcms_pkg::*;
#(
	parameter int DIV = `RCMS_DIV_RATIO,
	parameter int RST_HOLD = `RCMS_RST_HOLD_SYSCLK,
	parameter int MODE_GAP = `RCMS_MODE_GAP_SYSCLK,
	parameter int FETCH_HALF = `RCMS_FETCH_HALF_SYSCLK,
	parameter int WAIT_POLL = `RCMS_WAIT_POLL_SYSCLK
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic reset_input_n,
	input wire logic mode_pin_i,
	output logic mode_pin_o,
	output logic mode_pin_oe,
	input wire logic wait_start,
	input wire logic irq_pending,
	input wire logic irq_enable,
	input wire logic bus_hold,
	output logic system_reset_output,
	output logic system_clock_output,
	output logic enhanced_mode,
	output logic core_run,
	output logic fetch_start,
	output logic exec_suspended,
	output logic wait_done,
	output logic irq_take,
	output logic coproc_busy
);

	localparam int CW = `RCMS_CNT_W;
	localparam int SYNC = `RCMS_SYNC_STAGES;
	// Edges from pin release to the first read of the boot counter
	localparam int BOOT_LAT = SYNC + 2;
	localparam int RST_CLK = DIV * RST_HOLD;
	localparam int MODE_CLK = DIV * MODE_GAP;
	localparam int FETCH_CLK = (DIV * FETCH_HALF) / 2;
	localparam int POLL_CLK = DIV * WAIT_POLL;
	localparam logic [CW-1:0] DEASS_CNT = CW'(RST_CLK - BOOT_LAT);
	localparam logic [CW-1:0] MODE_CNT = CW'(MODE_CLK - 1);
	localparam logic [CW-1:0] FETCH_CNT = CW'(FETCH_CLK - BOOT_LAT);
	localparam logic [CW-1:0] POLL_MAX = CW'(POLL_CLK - 1);

	rcms_state_t state_q;
	logic [CW-1:0] cnt_q;
	logic res_sync;
	logic pin_sync;
	logic first_sample_q;
	logic clk_rise_next;
	logic boot_cnt_end;
	logic poll_hit;

	// Reset pin and mode pin share one synchroniser
	rcms_sync #(
		.W(2),
		.RST_VAL({`RCMS_RES_RST_VAL, `RCMS_PIN_RST_VAL})
	) u_sync (
		.clk(clk),
		.resetn(resetn),
		.d({reset_input_n, mode_pin_i}),
		.q({res_sync, pin_sync}) // R10
	);

	// Only power-on stops the divider, so it runs through reset and hold
	rcms_clkdiv u_div (
		.clk(clk),
		.resetn(resetn),
		.clk_half_q(system_clock_output), // R6 R7 R8
		.rise_next(clk_rise_next)
	);

	assign boot_cnt_end = (cnt_q == FETCH_CNT);
	assign poll_hit = (cnt_q == POLL_MAX);

	// Sequencer; a low synchronised reset pin wins from every state
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= RCMS_ST_RESET;
		end else if (!res_sync) begin
			state_q <= RCMS_ST_RESET; // R9
		end else begin
			unique case (state_q)
				RCMS_ST_RESET: begin
					state_q <= RCMS_ST_BOOT;
				end
				RCMS_ST_BOOT: begin
					if (boot_cnt_end) begin
						state_q <= RCMS_ST_RUN; // R11
					end
				end
				RCMS_ST_RUN: begin
					if (wait_start && !enhanced_mode && pin_sync) begin
						state_q <= RCMS_ST_WAIT; // R17
					end
				end
				RCMS_ST_WAIT: begin
					if (irq_pending && irq_enable) begin
						state_q <= RCMS_ST_RUN; // R19
					end else if (poll_hit && !pin_sync) begin
						state_q <= RCMS_ST_RUN; // R18
					end
				end
			endcase
		end
	end

	// Shared counter: boot timing, then wait polling
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_q <= '0;
		end else if (!res_sync || state_q == RCMS_ST_RESET) begin
			cnt_q <= '0;
		end else if (state_q == RCMS_ST_BOOT) begin
			cnt_q <= cnt_q + CW'(1);
		end else if (state_q == RCMS_ST_WAIT && !poll_hit) begin
			cnt_q <= cnt_q + CW'(1); // R18
		end else begin
			cnt_q <= '0;
		end
	end

	// Reset output follows the pin length in whole clock edges.
	// Bus hold is deliberately not an input here: never floated.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			system_reset_output <= 1'h1;
		end else if (!res_sync) begin
			system_reset_output <= 1'h1; // R1 R2
		end else if (state_q == RCMS_ST_BOOT && cnt_q == DEASS_CNT) begin
			system_reset_output <= 1'h0; // R3 R5
		end
	end

	// First mode sample at the release, second four periods later
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			first_sample_q <= 1'h0;
		end else if (state_q == RCMS_ST_RESET && res_sync) begin
			first_sample_q <= pin_sync; // R13
		end
	end

	// Reset tied to the pin reads high then low, giving enhanced
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			enhanced_mode <= 1'h0;
		end else if (!res_sync) begin
			enhanced_mode <= 1'h0;
		end else if (state_q == RCMS_ST_BOOT && cnt_q == MODE_CNT) begin
			enhanced_mode <= first_sample_q && !pin_sync; // R4 R14 R15
		end
	end

	// Pin is never driven by this block; reset forces input direction
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			mode_pin_oe <= 1'h0;
			mode_pin_o <= 1'h0;
		end else begin
			mode_pin_oe <= 1'h0; // R16
			mode_pin_o <= 1'h0;
		end
	end

	// Core status and one-cycle event pulses
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			core_run <= 1'h0;
			fetch_start <= 1'h0;
			exec_suspended <= 1'h0;
			wait_done <= 1'h0;
			irq_take <= 1'h0;
		end else if (!res_sync) begin
			core_run <= 1'h0; // R9
			fetch_start <= 1'h0;
			exec_suspended <= 1'h0;
			wait_done <= 1'h0;
			irq_take <= 1'h0;
		end else begin
			fetch_start <= state_q == RCMS_ST_BOOT && boot_cnt_end; // R11
			core_run <= state_q == RCMS_ST_RUN ||
				(state_q == RCMS_ST_BOOT && boot_cnt_end);
			exec_suspended <= (state_q == RCMS_ST_RUN && wait_start &&
				!enhanced_mode && pin_sync) ||
				(state_q == RCMS_ST_WAIT && !(irq_pending && irq_enable) &&
				!(poll_hit && !pin_sync)); // R17
			// WAIT with a low pin or in enhanced mode completes at once
			wait_done <= (state_q == RCMS_ST_RUN && wait_start &&
				(enhanced_mode || !pin_sync)) ||
				(state_q == RCMS_ST_WAIT && !(irq_pending && irq_enable) &&
				poll_hit && !pin_sync); // R18
			irq_take <= state_q == RCMS_ST_WAIT && irq_pending &&
				irq_enable; // R19
		end
	end

	// Busy level for floating-point issue, only in enhanced mode
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			coproc_busy <= 1'h0;
		end else begin
			coproc_busy <= enhanced_mode && pin_sync; // R20
		end
	end

	AST_RST_ACTIVE: assert property (@(posedge clk) disable iff (!resetn) // R1
		!res_sync |=> system_reset_output)
		else $error("reset output not asserted for held reset input");

	AST_RST_HOLD: assert property (@(posedge clk) disable iff (!resetn) // R2
		$rose(res_sync) |=> system_reset_output)
		else $error("reset output dropped too early");

	AST_RST_DEASSERT: assert property (@(posedge clk) // R3
		disable iff (!resetn)
		$rose(res_sync) ##1 res_sync ##1 res_sync |-> !system_reset_output)
		else $error("reset output not released two periods after input");

	// Needs one edge out of power-on reset before the divider moves
	AST_CLK_TOGGLE: assert property (@(posedge clk) disable iff (!resetn) // R8
		$past(resetn) |-> system_clock_output != $past(system_clock_output))
		else $error("system clock stopped toggling");

	AST_FETCH_TIME: assert property (@(posedge clk) disable iff (!resetn) // R11
		fetch_start |-> $past(res_sync, 11) && !$past(res_sync, 12))
		else $error("first fetch at wrong distance from release");

	AST_MODE_PICK: assert property (@(posedge clk) disable iff (!resetn) // R14
		fetch_start |-> enhanced_mode ==
			($past(pin_sync, 11) && !$past(pin_sync, 3)))
		else $error("mode chosen from wrong pin samples");

	AST_WAIT_SUSPEND: assert property (@(posedge clk) // R17
		disable iff (!resetn)
		state_q == RCMS_ST_RUN && res_sync && wait_start && !enhanced_mode &&
		pin_sync |=> exec_suspended)
		else $error("wait with high pin did not suspend");

	AST_WAIT_RESUME: assert property (@(posedge clk) disable iff (!resetn) // R18
		$fell(exec_suspended) && wait_done |->
			!$past(pin_sync) && $past(cnt_q) == POLL_MAX)
		else $error("resumed off the poll point or with high pin");

	AST_IRQ_WAIT: assert property (@(posedge clk) disable iff (!resetn) // R19
		irq_take |-> $past(exec_suspended) && $past(irq_pending) &&
			$past(irq_enable))
		else $error("interrupt taken outside an enabled wait");

	AST_BUSY_PASS: assert property (@(posedge clk) disable iff (!resetn) // R20
		enhanced_mode |=> coproc_busy == $past(pin_sync))
		else $error("busy level not passed in enhanced mode");

	AST_PIN_INPUT: assert property (@(posedge clk) disable iff (!resetn) // R16
		system_reset_output |-> !mode_pin_oe)
		else $error("mode pin driven during reset");

	AST_RST_FOLLOW: assert property (@(posedge clk) // R2
		disable iff (!resetn)
		res_sync && !system_reset_output |=> !system_reset_output)
		else $error("reset output rose with the input released");

	AST_RST_SYNCED: assert property (@(posedge clk) // R10
		disable iff (!resetn)
		$rose(system_reset_output) |-> !$past(res_sync))
		else $error("reset output rose without a synchronised low input");

	AST_CORE_CLEAR: assert property (@(posedge clk) // R9
		disable iff (!resetn)
		!res_sync |=> !core_run && !exec_suspended && !fetch_start)
		else $error("core activity survived a held reset input");

	AST_MODE_CLEAR: assert property (@(posedge clk) // R9
		disable iff (!resetn)
		!res_sync |=> !enhanced_mode)
		else $error("mode not cleared by a held reset input");

	AST_MODE_STABLE: assert property (@(posedge clk) // R13
		disable iff (!resetn)
		res_sync && !(state_q == RCMS_ST_BOOT && cnt_q == MODE_CNT) |=>
			$stable(enhanced_mode))
		else $error("mode changed outside its sample point");

	AST_FETCH_PULSE: assert property (@(posedge clk) // R11
		disable iff (!resetn)
		fetch_start |=> !fetch_start)
		else $error("first fetch pulse longer than one cycle");

	AST_FETCH_RUN: assert property (@(posedge clk) // R11
		disable iff (!resetn)
		fetch_start |-> core_run)
		else $error("first fetch without the core running");

	AST_SUSP_COMPAT: assert property (@(posedge clk) // R17
		disable iff (!resetn)
		exec_suspended |-> !enhanced_mode)
		else $error("suspended on the pin in enhanced mode");

	AST_POLL_RANGE: assert property (@(posedge clk) // R18
		disable iff (!resetn)
		state_q == RCMS_ST_WAIT |-> cnt_q <= POLL_MAX)
		else $error("poll counter beyond its period");

	AST_WAIT_HOLD: assert property (@(posedge clk) // R18
		disable iff (!resetn)
		state_q == RCMS_ST_WAIT && res_sync && pin_sync &&
			!(irq_pending && irq_enable) |=> exec_suspended)
		else $error("resumed while the pin was still high");

	AST_IRQ_NO_DONE: assert property (@(posedge clk) // R19
		disable iff (!resetn)
		irq_take |-> !wait_done)
		else $error("interrupt exit also flagged wait completion");

	AST_BUSY_COMPAT: assert property (@(posedge clk) // R20
		disable iff (!resetn)
		!enhanced_mode |=> !coproc_busy)
		else $error("busy level passed in compatible mode");

	AST_ENH_WAIT: assert property (@(posedge clk) // R20
		disable iff (!resetn)
		state_q == RCMS_ST_RUN && res_sync && wait_start && enhanced_mode |=>
			wait_done && !exec_suspended)
		else $error("wait in enhanced mode did not complete at once");

	COV_SUSPEND: cover property (@(posedge clk) disable iff (!resetn)
		$rose(exec_suspended));

	COV_ENHANCED: cover property (@(posedge clk) disable iff (!resetn)
		fetch_start && enhanced_mode);

	COV_WAIT_POLL: cover property (@(posedge clk) disable iff (!resetn)
		$fell(exec_suspended) && wait_done);

	COV_WAIT_IRQ: cover property (@(posedge clk) disable iff (!resetn)
		irq_take);

	COV_HOLD_RUN: cover property (@(posedge clk) disable iff (!resetn)
		bus_hold && core_run && clk_rise_next);

endmodule

/* File: verification/rcms_board.sv */
// Board reset circuit and coprocessor side of the mode pin
// Assumes the bench drives its requests by non-blocking assignment
`timescale 1ns/1ps
module rcms_board (
	input wire logic clk,
	input wire logic rst_req_n,
	input wire logic drv_en,
	input wire logic drv_val,
	input wire logic tie,
	input wire logic system_reset_output,
	input wire logic mode_pin_o,
	input wire logic mode_pin_oe,
	output logic reset_input_n,
	output logic mode_pin_i
);
	int low_cnt = 0;
	logic req_q = 1'h0;

	// Short requests are stretched, a glitch would not boot cleanly.
	// Count restarts only on a new request, so a release holds.
	always @(posedge clk) begin
		req_q <= rst_req_n;
		if (!rst_req_n && req_q)
			low_cnt <= 1;
		else if (low_cnt < 10)
			low_cnt <= low_cnt + 1;
	end
	assign reset_input_n = rst_req_n && low_cnt >= 10;

	// Weak pull-up wins only when nobody drives the pin
	assign mode_pin_i = mode_pin_oe ? mode_pin_o : tie ? system_reset_output :
		drv_en ? drv_val : 1'h1;
endmodule

/* File: verification/tb_reset_clock_mode_select.sv */
// Self-checking bench of the reset, clock and mode-select block
// Assumes the board model file and the design files are compiled first
`timescale 1ns/1ps
module tb_reset_clock_mode_select;
	import rcms_pkg::*;
	logic clk = 1'h0, resetn = 1'h0, rst_req_n = 1'h0, drv_en = 1'h1;
	logic drv_val = 1'h1, tie = 1'h0, wait_start = 1'h0, bus_hold = 1'h0;
	logic irq_pending = 1'h0, irq_enable = 1'h0, last_clk = 1'h0;
	logic reset_input_n, mode_pin_i, mode_pin_o, mode_pin_oe, coproc_busy;
	logic system_reset_output, system_clock_output, enhanced_mode, core_run;
	logic fetch_start, exec_suspended, wait_done, irq_take;
	logic clk_armed = 1'h0;
	int num_errors = 0, samples_checked = 0;

	always #2 clk = ~clk;

	rcms_board rcms_board_i (.clk(clk), .rst_req_n(rst_req_n),
		.drv_en(drv_en), .drv_val(drv_val), .tie(tie),
		.system_reset_output(system_reset_output), .mode_pin_o(mode_pin_o),
		.mode_pin_oe(mode_pin_oe), .reset_input_n(reset_input_n),
		.mode_pin_i(mode_pin_i));

	rcms_top rcms_top_i (.clk(clk), .resetn(resetn),
		.reset_input_n(reset_input_n), .mode_pin_i(mode_pin_i),
		.mode_pin_o(mode_pin_o), .mode_pin_oe(mode_pin_oe),
		.wait_start(wait_start), .irq_pending(irq_pending),
		.irq_enable(irq_enable), .bus_hold(bus_hold),
		.system_reset_output(system_reset_output),
		.system_clock_output(system_clock_output),
		.enhanced_mode(enhanced_mode), .core_run(core_run),
		.fetch_start(fetch_start), .exec_suspended(exec_suspended),
		.wait_done(wait_done), .irq_take(irq_take),
		.coproc_busy(coproc_busy));

	task automatic check(input string what, input logic seen, input logic exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s expected %b seen %b", what, exp, seen);
		end
	endtask

	task automatic complete_run;
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Bus hold toggles freely, the clock must not care
	always @(posedge clk) begin
		bus_hold <= 1'($urandom_range(0, 1));
		#1;
		// First edge out of power-on reset leaves the divider at zero
		if (resetn && clk_armed)
			check("sys_clock", system_clock_output, !last_clk);
		clk_armed = resetn;
		last_clk = system_clock_output;
	end

	task automatic boot(input logic a, input logic b, input logic t);
		@(posedge clk);
		rst_req_n <= 1'h0;
		tie <= t;
		drv_en <= 1'h1;
		drv_val <= a;
		repeat (3) @(posedge clk);
		#1;
		check("reset_out", system_reset_output, 1'h1);
		check("core_run", core_run, 1'h0);
		check("pin_oe", mode_pin_oe, 1'h0);
		check("pin_out", mode_pin_o, 1'h0);
		repeat (8) @(posedge clk);
		rst_req_n <= 1'h1;
		for (int k = 1; k <= 14; k++) begin
			@(posedge clk);
			if (k == 4)
				drv_val <= b;
			#1;
			check("reset_out", system_reset_output, k < 4);
			check("fetch", fetch_start, k == 13);
			check("run", core_run, k >= 13);
		end
		check("enhanced", enhanced_mode, t | (a & !b));
		tie <= 1'h0;
	endtask

	task automatic wait_test(input logic use_irq);
		int n;
		@(posedge clk);
		drv_en <= 1'h0;
		irq_pending <= use_irq;
		repeat (3) @(posedge clk);
		wait_start <= 1'h1;
		@(posedge clk);
		wait_start <= 1'h0;
		repeat ($urandom_range(1, 25)) begin
			#1;
			check("suspend", exec_suspended, 1'h1);
			@(posedge clk);
		end
		drv_en <= 1'h1;
		drv_val <= 1'h0;
		irq_enable <= use_irq;
		// Pulses are looked at after the edge that launches them
		for (n = 1; n <= 20; n++) begin
			@(posedge clk);
			#1;
			if (wait_done === 1'h1 || irq_take === 1'h1)
				break;
		end
		check("irq_take", irq_take, use_irq);
		check("wait_done", wait_done, !use_irq);
		check("poll_bound", n <= 14, 1'h1);
		@(posedge clk);
		irq_pending <= 1'h0;
		irq_enable <= 1'h0;
	endtask

	initial begin
		void'($urandom(24787));
		repeat (5) @(posedge clk);
		resetn <= 1'h1;
		for (int i = 0; i < 4; i++)
			boot(i[1], i[0], 1'h0);
		boot(1'h0, 1'h0, 1'h1);
		repeat (3)
			boot(1'($urandom_range(0, 1)), 1'($urandom_range(0, 1)), 1'h0);
		boot(1'h0, 1'h0, 1'h0);
		wait_test(1'h0);
		wait_test(1'h1);
		boot(1'h1, 1'h0, 1'h0);
		repeat (6) begin
			drv_val <= 1'($urandom_range(0, 1));
			repeat (3) @(posedge clk);
			#1;
			check("busy", coproc_busy, drv_val);
		end
		@(posedge clk);
		wait_start <= 1'h1;
		@(posedge clk);
		wait_start <= 1'h0;
		#1;
		check("enh_wait", wait_done, 1'h1);
		complete_run();
	end

	initial begin
		#100000;
		num_errors++;
		complete_run();
	end
endmodule
